//--- rtl/cycle_counter.sv
// Valid-cycle counter with compare match and auto clear
`timescale 1ns/1ps
module cycle_counter #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Events and compare
  input  wire logic         i_valid_cycle,
  input  wire logic [W-1:0] i_compare,
  output logic      [W-1:0] o_count,
  output logic              o_match
);
  wire [W-1:0] next_count = o_count + W'(1);
  wire         hit        = i_valid_cycle && (next_count == i_compare);

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_count <= '0;
      o_match <= 1'b0;
    end
    else
    begin
      o_match <= hit;
      if (hit)
        o_count <= '0;
      else if (i_valid_cycle)
        o_count <= next_count;
    end
  end
endmodule

//--- rtl/slave_host_ctrl.sv
// Processor and master end: init sequence, state poll, cycle and message driver
`include "slv_defines.svh"
`timescale 1ns/1ps
module slave_host_ctrl (
  // Clock and reset
  input  wire logic       I_MCLK,
  input  wire logic       I_RST,
  // Init request
  input  wire logic       I_INIT_REQ,
  input  wire logic [7:0] I_LEN_CFG,
  input  wire logic [7:0] I_IDENT,
  input  wire logic [7:0] I_SWITCH,
  // Read request
  input  wire logic       I_RD_REQ,
  input  wire logic [2:0] I_RD_ADDR,
  output logic [7:0]      O_RD_DATA,
  output logic            O_RD_DONE,
  output logic            O_BUS_RESET_SEEN,
  output logic            O_BUSY,
  // Single register write, taken in idle only
  input  wire logic       I_WR_REQ,
  input  wire logic [2:0] I_WR_ADDR,
  input  wire logic [7:0] I_WR_DATA,
  // Master side
  input  wire logic       I_VALID_CYCLE,
  input  wire logic       I_CHECK_SEQ,
  input  wire logic       I_ALARM_STOP,
  input  wire logic       I_MGMT_ENABLE,
  input  wire logic       I_MGMT_SEND,
  input  wire logic [7:0] I_MGMT_DATA,
  // Link
  slv_link_if.host        LINK
);
  slv_pkg::host_state_t state;
  slv_pkg::host_state_t next_state;
  logic [7:0] len_q;
  logic [7:0] id_q;
  logic [7:0] sw_q;
  logic [2:0] rd_addr_q;

  always_comb
  begin
    case (state)
      slv_pkg::H_IDLE:  next_state = I_INIT_REQ ? slv_pkg::H_W_LEN :
                                     (I_RD_REQ ? slv_pkg::H_RD : slv_pkg::H_IDLE);
      slv_pkg::H_W_LEN: next_state = slv_pkg::H_W_ID;
      slv_pkg::H_W_ID:  next_state = slv_pkg::H_W_SW;
      slv_pkg::H_W_SW:  next_state = slv_pkg::H_IDLE;
      slv_pkg::H_RD:    next_state = slv_pkg::H_WAIT;
      slv_pkg::H_WAIT:  next_state = LINK.cpu_rd_ack ? slv_pkg::H_IDLE : slv_pkg::H_WAIT;
      default:          next_state = slv_pkg::H_IDLE;
    endcase
  end

  // Lone write stays in idle; init and read requests win
  wire one_wr = (state == slv_pkg::H_IDLE) && !I_INIT_REQ && !I_RD_REQ && I_WR_REQ;
  wire do_wr = (next_state == slv_pkg::H_W_LEN) || (next_state == slv_pkg::H_W_ID)
            || (next_state == slv_pkg::H_W_SW) || one_wr;
  wire [2:0] wr_addr = (next_state == slv_pkg::H_W_LEN) ? `AD_LEN_CFG :
                       ((next_state == slv_pkg::H_W_ID) ? `AD_IDENT : `AD_SWITCH);
  wire [7:0] wr_data = (next_state == slv_pkg::H_W_LEN) ? I_LEN_CFG :
                       ((next_state == slv_pkg::H_W_ID) ? id_q : sw_q);
  wire do_rd = (next_state == slv_pkg::H_RD);
  wire got   = (state == slv_pkg::H_WAIT) && LINK.cpu_rd_ack;
  // Reserved bus state bits carry no meaning
  wire [7:0] rd_val = (rd_addr_q == `AD_BUS_STATE) ? (LINK.cpu_rdata & `BS_MASK)
                                                   : LINK.cpu_rdata;

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state            <= slv_pkg::H_IDLE;
      len_q            <= `BYTE_ZERO;
      id_q             <= `BYTE_ZERO;
      sw_q             <= `BYTE_ZERO;
      rd_addr_q        <= 3'h0;
      O_RD_DATA        <= `BYTE_ZERO;
      O_RD_DONE        <= 1'b0;
      O_BUS_RESET_SEEN <= 1'b0;
      O_BUSY           <= 1'b0;
      LINK.cpu_wr      <= 1'b0;
      LINK.cpu_rd      <= 1'b0;
      LINK.cpu_addr    <= 3'h0;
      LINK.cpu_wdata   <= `BYTE_ZERO;
    end
    else
    begin
      state <= next_state;
      if (state == slv_pkg::H_IDLE && I_INIT_REQ)
      begin
        len_q <= I_LEN_CFG;
        id_q  <= I_IDENT;
        sw_q  <= I_SWITCH;
      end
      if (do_rd)
        rd_addr_q <= I_RD_ADDR;
      LINK.cpu_wr    <= do_wr;
      LINK.cpu_rd    <= do_rd;
      LINK.cpu_addr  <= do_rd ? I_RD_ADDR : (one_wr ? I_WR_ADDR : wr_addr);
      LINK.cpu_wdata <= do_wr ? (one_wr ? I_WR_DATA : wr_data) : `BYTE_ZERO;
      O_RD_DONE      <= got;
      if (got)
      begin
        O_RD_DATA <= rd_val;
        if (rd_addr_q == `AD_BUS_STATE)
          O_BUS_RESET_SEEN <= rd_val[`BS_RESET];
      end
      O_BUSY <= (next_state != slv_pkg::H_IDLE);
    end
  end

  // Master side drive; messages only flow once the channel is enabled
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      LINK.valid_cycle <= 1'b0;
      LINK.check_seq   <= 1'b0;
      LINK.alarm_stop  <= 1'b0;
      LINK.mgmt_en     <= 1'b0;
      LINK.mgmt_valid  <= 1'b0;
      LINK.mgmt_data   <= `BYTE_ZERO;
    end
    else
    begin
      LINK.valid_cycle <= I_VALID_CYCLE;
      LINK.check_seq   <= I_CHECK_SEQ;
      LINK.alarm_stop  <= I_ALARM_STOP;
      LINK.mgmt_en     <= I_MGMT_ENABLE;
      LINK.mgmt_valid  <= I_MGMT_SEND && LINK.mgmt_en;
      LINK.mgmt_data   <= I_MGMT_DATA;
    end
  end
endmodule

//--- rtl/slave_init_regs.sv
// Slave-side init, lock and status register bank
`include "slv_defines.svh"
`timescale 1ns/1ps
module slave_init_regs (
  // Clock and reset
  input  wire logic       I_MCLK,
  input  wire logic       I_RST,
  // Strap pins
  input  wire logic [7:0] I_IDENT_PINS_LOW,
  input  wire logic [4:0] I_LENGTH_PINS,
  input  wire logic       I_CFG_MODE_PIN_HI,
  input  wire logic       I_CFG_MODE_PIN_LO,
  // Fault that forces bus reset
  input  wire logic       I_FATAL_ERR,
  // Effective identification and status
  output logic [7:0]      O_IDENT_LOW,
  output logic [4:0]      O_IDENT_LENGTH,
  output logic            O_DEFERRED,
  output logic            O_LOCKED,
  output logic            O_IN_BUS_RESET,
  output logic [7:0]      O_PDATA,
  // Link
  slv_link_if.dev         LINK
);
  // Pin synchronisers
  logic [7:0] id_s1;
  logic [7:0] id_s2;
  logic [4:0] len_s1;
  logic [4:0] len_s2;
  logic [2:0] misc_s1;
  logic [2:0] misc_s2;
  // Straps captured after reset release
  logic       strap_taken;
  logic [7:0] strap_id;
  logic [4:0] strap_len;
  // Registers
  logic [7:0] length_config;
  logic [7:0] switch_config;
  logic [7:0] soft_ident_byte;
  logic       locked;
  logic       reset_flag;
  logic       in_reset_d;
  logic [7:0] irq_en;
  logic [7:0] events;
  logic [7:0] cyc_compare;
  logic [7:0] proc_cmd;
  logic [7:0] cyc_count;
  logic       cyc_match;

  // No reset: straps must already be through both stages when reset lifts
  always_ff @(posedge I_MCLK)
  begin
    id_s1   <= I_IDENT_PINS_LOW;
    id_s2   <= id_s1;
    len_s1  <= I_LENGTH_PINS;
    len_s2  <= len_s1;
    misc_s1 <= {I_CFG_MODE_PIN_HI, I_CFG_MODE_PIN_LO, I_FATAL_ERR};
    misc_s2 <= misc_s1;
  end

  wire cfg_hi = misc_s2[2];
  wire cfg_lo = misc_s2[1];
  wire fatal  = misc_s2[0];

  // Straps are latched once so a pin glitch later cannot change identity
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      strap_taken <= 1'b0;
      strap_id    <= `BYTE_ZERO;
      strap_len   <= `LEN_ZERO;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      strap_id    <= id_s2;
      strap_len   <= len_s2;
    end
  end

  wire deferred = (strap_id == `DEFER_REMOTE) || (strap_id == `DEFER_LOCAL);
  wire len_ovr  = switch_config[`SW_LEN_OVR];
  // Ident override only counts together with length override
  wire id_ovr   = switch_config[`SW_ID_OVR] && len_ovr;
  wire [4:0] soft_len = length_config[`LEN_HI:`LEN_LO];
  wire [4:0] eff_len  = len_ovr ? soft_len :
                        (deferred ? `LEN_ZERO : strap_len);
  wire [7:0] eff_id   = id_ovr ? soft_ident_byte : strap_id;

  // Write decode; once locked, length, switch and ident writes simply fall on the floor
  wire wr_open   = LINK.cpu_wr && !locked;
  wire wr_len    = wr_open && (LINK.cpu_addr == `AD_LEN_CFG);
  wire wr_sw     = wr_open && (LINK.cpu_addr == `AD_SWITCH);
  wire wr_id     = wr_open && (LINK.cpu_addr == `AD_IDENT);
  wire wr_pdata  = LINK.cpu_wr && (LINK.cpu_addr == `AD_PDATA);
  wire wr_irq_en = LINK.cpu_wr && (LINK.cpu_addr == `AD_IRQ_EN);
  wire wr_clr    = LINK.cpu_wr && (LINK.cpu_addr == `AD_EVT_CLR);
  wire wr_cmp    = LINK.cpu_wr && (LINK.cpu_addr == `AD_CYC);
  wire rd_state  = LINK.cpu_rd && (LINK.cpu_addr == `AD_BUS_STATE);

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      length_config   <= `BYTE_ZERO;
      switch_config   <= `BYTE_ZERO;
      soft_ident_byte <= `BYTE_ZERO;
      locked          <= 1'b0;
    end
    else
    begin
      if (wr_len)
        length_config <= LINK.cpu_wdata;
      if (wr_id)
        soft_ident_byte <= LINK.cpu_wdata;
      if (wr_sw)
      begin
        switch_config <= LINK.cpu_wdata;
        locked        <= 1'b1;
      end
    end
  end

  // Bus reset: entered on fatal error or alarm stop
  wire in_reset   = fatal || LINK.alarm_stop;
  wire reset_rise = in_reset && !in_reset_d;

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      in_reset_d <= 1'b0;
      reset_flag <= 1'b0;
      O_PDATA    <= `BYTE_ZERO;
    end
    else
    begin
      in_reset_d <= in_reset;
      // Entry wins over a read in the same cycle
      if (reset_rise)
        reset_flag <= 1'b1;
      else if (rd_state)
        reset_flag <= 1'b0;
      if (reset_rise)
        O_PDATA <= `BYTE_ZERO;
      else if (wr_pdata)
        O_PDATA <= LINK.cpu_wdata;
    end
  end

  cycle_counter #(
    .W (8)
  ) u_cycle_counter (
    .i_clk         (I_MCLK),
    .i_rst         (I_RST),
    .i_valid_cycle (LINK.valid_cycle),
    .i_compare     (cyc_compare),
    .o_count       (cyc_count),
    .o_match       (cyc_match)
  );

  wire mgmt_in = LINK.mgmt_en && LINK.mgmt_valid;
  wire [7:0] ev_set = (8'(cyc_match) << `EV_CYCLE) | (8'(mgmt_in) << `EV_MGMT);
  wire [7:0] ev_clr = wr_clr ? LINK.cpu_wdata : `BYTE_ZERO;

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      irq_en      <= `BYTE_ZERO;
      events      <= `BYTE_ZERO;
      cyc_compare <= `BYTE_ZERO;
      proc_cmd    <= `BYTE_ZERO;
    end
    else
    begin
      if (wr_irq_en)
        irq_en <= LINK.cpu_wdata;
      // Set wins over clear so no event is lost
      events <= (events & ~ev_clr) | ev_set;
      if (wr_cmp)
        cyc_compare <= LINK.cpu_wdata;
      if (mgmt_in)
        proc_cmd <= LINK.mgmt_data;
    end
  end

  wire [7:0] bus_state = {3'h0, cfg_hi, cfg_lo, LINK.check_seq, reset_flag, 1'b0};
  logic [7:0] rd_mux;
  always_comb
  begin
    case (LINK.cpu_addr)
      `AD_PDATA:     rd_mux = O_PDATA;
      `AD_EVT:       rd_mux = events;
      `AD_CYC:       rd_mux = cyc_count;
      `AD_PCMD:      rd_mux = proc_cmd;
      `AD_BUS_STATE: rd_mux = bus_state;
      default:       rd_mux = `BYTE_ZERO;
    endcase
  end

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      LINK.cpu_rdata  <= `BYTE_ZERO;
      LINK.cpu_rd_ack <= 1'b0;
      LINK.irq        <= 1'b0;
      O_IDENT_LOW     <= `BYTE_ZERO;
      O_IDENT_LENGTH  <= `LEN_ZERO;
      O_DEFERRED      <= 1'b0;
      O_LOCKED        <= 1'b0;
      O_IN_BUS_RESET  <= 1'b0;
    end
    else
    begin
      LINK.cpu_rd_ack <= LINK.cpu_rd;
      if (LINK.cpu_rd)
        LINK.cpu_rdata <= rd_mux;
      LINK.irq       <= |(events & irq_en);
      O_IDENT_LOW    <= eff_id;
      O_IDENT_LENGTH <= eff_len;
      O_DEFERRED     <= deferred;
      O_LOCKED       <= locked;
      O_IN_BUS_RESET <= in_reset;
    end
  end
endmodule

//--- rtl/slv_defines.svh
// Register addresses, bit positions and codes of the slave init/status bank
`ifndef SLV_DEFINES_SVH
`define SLV_DEFINES_SVH
`define AD_PDATA      3'h0
`define AD_IRQ_EN     3'h1
`define AD_EVT        3'h1
`define AD_EVT_CLR    3'h2
`define AD_CYC        3'h3
`define AD_PCMD       3'h4
`define AD_LEN_CFG    3'h5
`define AD_SWITCH     3'h6
`define AD_IDENT      3'h7
`define AD_BUS_STATE  3'h7
`define BS_CFG_HI     4
`define BS_CFG_LO     3
`define BS_CHECK      2
`define BS_RESET      1
`define BS_MASK       8'h1E
`define SW_LEN_OVR    0
`define SW_ID_OVR     6
`define LEN_HI        7
`define LEN_LO        3
`define EV_MGMT       0
`define EV_CYCLE      5
`define DEFER_REMOTE  8'h38
`define DEFER_LOCAL   8'h78
`define LEN_ZERO      5'h00
`define BYTE_ZERO     8'h00
`endif

//--- rtl/slv_link_if.sv
// Processor bus and master-side signals joining the two ends
`timescale 1ns/1ps
interface slv_link_if;
  logic       cpu_wr;
  logic       cpu_rd;
  logic [2:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic [7:0] cpu_rdata;
  logic       cpu_rd_ack;
  logic       irq;
  logic       valid_cycle;
  logic       check_seq;
  logic       alarm_stop;
  logic       mgmt_en;
  logic       mgmt_valid;
  logic [7:0] mgmt_data;
  modport dev (
    input  cpu_wr, cpu_rd, cpu_addr, cpu_wdata,
    output cpu_rdata, cpu_rd_ack, irq,
    input  valid_cycle, check_seq, alarm_stop, mgmt_en, mgmt_valid, mgmt_data
  );
  modport host (
    output cpu_wr, cpu_rd, cpu_addr, cpu_wdata,
    input  cpu_rdata, cpu_rd_ack, irq,
    output valid_cycle, check_seq, alarm_stop, mgmt_en, mgmt_valid, mgmt_data
  );
endinterface

//--- rtl/slv_pkg.sv
// State type of the processor end of the slave init/status link
package slv_pkg;
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_W_LEN = 3'b001,
    H_W_ID  = 3'b010,
    H_W_SW  = 3'b011,
    H_RD    = 3'b100,
    H_WAIT  = 3'b101
  } host_state_t;
endpackage

//--- testbench/slave_init_lock_status_regs_tb.sv
// Self-checking bench joining the slave bank to its processor end
`timescale 1ns/1ps
module slave_init_lock_status_regs_tb;
  logic       mclk, rst, cfg_hi, cfg_lo, fatal_err, deferred, locked, in_bus_reset;
  logic       init_req, rd_req, rd_done, bus_reset_seen, busy, valid_cycle, check_seq;
  logic       alarm_stop, mgmt_enable, mgmt_send, wr_req;
  logic [7:0] ident_pins, ident_low, pdata, len_cfg, ident, switch_val, rd_data, mgmt_data;
  logic [4:0] length_pins, ident_length;
  logic [2:0] rd_addr, wr_addr;
  logic [7:0] wr_data;
  logic [7:0] exp_q[$];
  string      name_q[$];
  int         num_errors, checks_done, cycles;

  slv_link_if u_slv_link_if ();
  slave_init_regs u_slave_init_regs (.I_MCLK(mclk), .I_RST(rst), .I_IDENT_PINS_LOW(ident_pins),
    .I_LENGTH_PINS(length_pins), .I_CFG_MODE_PIN_HI(cfg_hi), .I_CFG_MODE_PIN_LO(cfg_lo),
    .I_FATAL_ERR(fatal_err), .O_IDENT_LOW(ident_low), .O_IDENT_LENGTH(ident_length),
    .O_DEFERRED(deferred), .O_LOCKED(locked), .O_IN_BUS_RESET(in_bus_reset),
    .O_PDATA(pdata), .LINK(u_slv_link_if));
  slave_host_ctrl u_slave_host_ctrl (.I_MCLK(mclk), .I_RST(rst), .I_INIT_REQ(init_req),
    .I_LEN_CFG(len_cfg), .I_IDENT(ident), .I_SWITCH(switch_val), .I_RD_REQ(rd_req),
    .I_RD_ADDR(rd_addr), .O_RD_DATA(rd_data), .O_RD_DONE(rd_done),
    .I_WR_REQ(wr_req), .I_WR_ADDR(wr_addr), .I_WR_DATA(wr_data),
    .O_BUS_RESET_SEEN(bus_reset_seen), .O_BUSY(busy), .I_VALID_CYCLE(valid_cycle),
    .I_CHECK_SEQ(check_seq), .I_ALARM_STOP(alarm_stop), .I_MGMT_ENABLE(mgmt_enable),
    .I_MGMT_SEND(mgmt_send), .I_MGMT_DATA(mgmt_data), .LINK(u_slv_link_if));
  slv_link_sva u_slv_link_sva (.I_MCLK(mclk), .I_RST(rst), .cpu_wr(u_slv_link_if.cpu_wr),
    .cpu_rd(u_slv_link_if.cpu_rd), .cpu_addr(u_slv_link_if.cpu_addr),
    .cpu_wdata(u_slv_link_if.cpu_wdata), .cpu_rdata(u_slv_link_if.cpu_rdata),
    .cpu_rd_ack(u_slv_link_if.cpu_rd_ack), .irq(u_slv_link_if.irq),
    .valid_cycle(u_slv_link_if.valid_cycle), .check_seq(u_slv_link_if.check_seq),
    .alarm_stop(u_slv_link_if.alarm_stop), .mgmt_en(u_slv_link_if.mgmt_en),
    .mgmt_valid(u_slv_link_if.mgmt_valid), .mgmt_data(u_slv_link_if.mgmt_data));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic final_report();
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  // Expected read result is queued; the monitor below compares it
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
    exp_q.push_back(e);
    name_q.push_back(n);
    rd_addr = a;
    rd_req = 1'b1;
    tick(1);
    rd_req = 1'b0;
    while (rd_done !== 1'b1)
      tick(1);
    tick(1);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    wr_addr = a;
    wr_data = d;
    wr_req = 1'b1;
    tick(1);
    wr_req = 1'b0;
    tick(2);
  endtask

  task automatic init(input logic [7:0] l, input logic [7:0] d, input logic [7:0] s);
    len_cfg = l;
    ident = d;
    switch_val = s;
    init_req = 1'b1;
    tick(1);
    init_req = 1'b0;
    tick(6);
  endtask

  task automatic send_msg(input logic [7:0] d);
    mgmt_data = d;
    mgmt_send = 1'b1;
    tick(1);
    mgmt_send = 1'b0;
    tick(4);
  endtask

  // Gaps between pulses are invalid cycles and must not count
  task automatic vc(input int n);
    repeat (n)
    begin
      valid_cycle = 1'b1;
      tick(1);
      valid_cycle = 1'b0;
      tick(1);
    end
    tick(2);
  endtask

  always @(posedge mclk)
    if (rd_done === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unexpected_read", 8'h00, 8'hFF);
      else
        check(name_q.pop_front(), exp_q.pop_front(), rd_data);
    end

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end

  initial
  begin
    logic [31:0] seed;
    logic [7:0]  code, lc, idv, sw, flip, cmp;
    logic        dfr;
    int          n;
    seed = 32'hD45D;
    {rst, init_req, rd_req, valid_cycle, check_seq, alarm_stop} = 6'h3F & 6'h20;
    {mgmt_enable, mgmt_send, fatal_err, cfg_hi, cfg_lo} = 5'h00;
    {len_cfg, ident, switch_val, mgmt_data, ident_pins} = 40'h00;
    {rd_addr, length_pins, wr_req, wr_addr, wr_data} = 20'h00000;
    for (int i = 0; i < 3; i++)
    begin
      seed = xs(seed);
      code = (i == 0) ? 8'h38 : (i == 1) ? 8'h78 : seed[7:0] & 8'hF7;
      dfr = (i < 2);
      {lc, idv} = seed[31:16];
      sw = dfr ? 8'h41 : 8'h01;
      rst = 1'b1;
      mgmt_enable = 1'b0;
      ident_pins = code;
      {cfg_hi, cfg_lo, length_pins} = seed[14:8];
      tick(16);
      rst = 1'b0;
      tick(3);
      check("deferred", {7'h00, dfr}, {7'h00, deferred});
      check("ident_low", code, ident_low);
      check("ident_length", {3'h0, dfr ? 5'h00 : length_pins}, {3'h0, ident_length});
      check("locked", 8'h00, {7'h00, locked});
      for (int j = 0; j < 2; j++)
      begin
        flip = (j == 1) ? 8'hFF : 8'h00;
        init(lc ^ flip, idv ^ flip, (j == 1) ? 8'h41 : sw);
        check("locked", 8'h01, {7'h00, locked});
        check("ident_length", {3'h0, lc[7:3]}, {3'h0, ident_length});
        check("ident_low", dfr ? idv : code, ident_low);
      end
      send_msg(~seed[7:0]);
      rd(3'h1, 8'h00, "events");
      mgmt_enable = 1'b1;
      tick(3);
      send_msg(seed[7:0]);
      rd(3'h4, seed[7:0], "command");
      rd(3'h1, 8'h01, "events");
      n = int'(seed[5:0]) + 1;
      vc(n);
      rd(3'h3, n[7:0], "cycle_count");
      vc(256 - n);
      rd(3'h3, 8'h00, "cycle_count");
      rd(3'h1, 8'h21, "events");
      cmp = {4'h0, seed[19:16]} + 8'h02;
      wr(3'h3, cmp);
      wr(3'h2, 8'hFF);
      wr(3'h1, 8'h20);
      rd(3'h1, 8'h00, "events");
      vc(int'(cmp) - 1);
      rd(3'h3, cmp - 8'h01, "cycle_count");
      check("irq", 8'h00, {7'h00, u_slv_link_if.irq});
      vc(1);
      rd(3'h3, 8'h00, "cycle_count");
      check("irq", 8'h01, {7'h00, u_slv_link_if.irq});
      rd(3'h1, 8'h20, "events");
      wr(3'h0, idv | 8'h01);
      rd(3'h0, idv | 8'h01, "pdata");
      rd(3'h6, 8'h00, "unmapped");
      check_seq = 1'b1;
      tick(4);
      rd(3'h7, {3'h0, cfg_hi, cfg_lo, 3'b100}, "bus_state");
      check_seq = 1'b0;
      alarm_stop = 1'b1;
      tick(5);
      check("in_bus_reset", 8'h01, {7'h00, in_bus_reset});
      rd(3'h7, {3'h0, cfg_hi, cfg_lo, 3'b010}, "bus_state");
      check("bus_reset_seen", 8'h01, {7'h00, bus_reset_seen});
      rd(3'h7, {3'h0, cfg_hi, cfg_lo, 3'b000}, "bus_state");
      check("pdata", 8'h00, pdata);
      alarm_stop = 1'b0;
      tick(2);
      fatal_err = 1'b1;
      tick(6);
      check("in_bus_reset", 8'h01, {7'h00, in_bus_reset});
      rd(3'h7, {3'h0, cfg_hi, cfg_lo, 3'b010}, "bus_state");
      fatal_err = 1'b0;
      tick(2);
    end
    check("pending_reads", 8'h00, 8'(exp_q.size()));
    final_report();
  end
endmodule

//--- testbench/slv_link_sva.sv
// Concurrent checks on the link between the slave bank and its processor end
`timescale 1ns/1ps
module slv_link_sva (
  // Clock and reset
  input  wire logic       I_MCLK,
  input  wire logic       I_RST,
  // Processor bus
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [2:0] cpu_addr,
  input  wire logic [7:0] cpu_wdata,
  input  wire logic [7:0] cpu_rdata,
  input  wire logic       cpu_rd_ack,
  input  wire logic       irq,
  // Master side
  input  wire logic       valid_cycle,
  input  wire logic       check_seq,
  input  wire logic       alarm_stop,
  input  wire logic       mgmt_en,
  input  wire logic       mgmt_valid,
  input  wire logic [7:0] mgmt_data
);
  logic [7:0] cnt_m;
  logic [7:0] cmp_m;
  logic [7:0] ev_m;
  logic [7:0] cmd_m;
  logic       armed;
  logic [3:0] age;
  wire        rd7     = cpu_rd && cpu_addr == 3'h7;
  wire  [7:0] cnt_inc = cnt_m + 8'h01;
  wire        hit     = valid_cycle && cnt_inc == cmp_m;
  wire        msg     = mgmt_valid && mgmt_en;
  wire  [7:0] ev_clr  = (cpu_wr && cpu_addr == 3'h2) ? cpu_wdata : 8'h00;
  wire  [7:0] ev_set  = {2'b00, hit, 4'h0, msg};

  // Shadow of counter, events and command seen from the bus alone
  always_ff @(posedge I_MCLK or posedge I_RST)
    if (I_RST)
    begin
      cnt_m <= 8'h00;
      cmp_m <= 8'h00;
      ev_m  <= 8'h00;
      cmd_m <= 8'h00;
    end
    else
    begin
      cnt_m <= valid_cycle ? (hit ? 8'h00 : cnt_inc) : cnt_m;
      cmp_m <= (cpu_wr && cpu_addr == 3'h3) ? cpu_wdata : cmp_m;
      ev_m  <= (ev_m & ~ev_clr) | ev_set;
      cmd_m <= msg ? mgmt_data : cmd_m;
    end

  // Bus reset entry by alarm stop pending until bus state is read
  always_ff @(posedge I_MCLK or posedge I_RST)
    if (I_RST)
    begin
      armed <= 1'b0;
      age   <= 4'h0;
    end
    else
    begin
      armed <= $rose(alarm_stop) ? 1'b1 : (rd7 ? 1'b0 : armed);
      age   <= $rose(alarm_stop) ? 4'h0 : (age == 4'hF ? age : age + 4'h1);
    end

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);

  sequence s_ident_then_switch;
    cpu_wr && cpu_addr == 3'h7 ##1 cpu_wr && cpu_addr == 3'h6;
  endsequence
  property p_init_order;
    cpu_wr && cpu_addr == 3'h5 |=> s_ident_then_switch;
  endproperty
  property p_rd_ack;
    cpu_rd |=> cpu_rd_ack;
  endproperty
  property p_ack_cause;
    cpu_rd_ack |-> $past(cpu_rd);
  endproperty
  property p_state_layout;
    rd7 |=> (cpu_rdata & 8'hE1) == 8'h00;
  endproperty
  property p_unmapped;
    cpu_rd && cpu_addr inside {3'h2, 3'h5, 3'h6} |=> cpu_rdata == 8'h00;
  endproperty
  property p_check_bit;
    rd7 && $stable(check_seq) && check_seq == $past(check_seq, 2)
      |=> cpu_rdata[2] == $past(check_seq);
  endproperty
  property p_reset_flag;
    rd7 && armed && age >= 4'h3 |=> cpu_rdata[1];
  endproperty
  property p_count;
    cpu_rd && cpu_addr == 3'h3 && !valid_cycle && !$past(valid_cycle)
      |=> cpu_rdata == $past(cnt_m);
  endproperty
  property p_events;
    cpu_rd && cpu_addr == 3'h1 && $stable(ev_m) && ev_m == $past(ev_m, 2)
      |=> cpu_rdata == $past(ev_m);
  endproperty
  property p_cmd;
    cpu_rd && cpu_addr == 3'h4 && !mgmt_valid && !$past(mgmt_valid)
      |=> cpu_rdata == $past(cmd_m);
  endproperty
  property p_mgmt_en;
    mgmt_valid |-> mgmt_en || $past(mgmt_en);
  endproperty

  a_init_order: assert property (p_init_order)
    else $error("init writes out of order");
  a_rd_ack: assert property (p_rd_ack)
    else $error("read not answered next cycle");
  a_ack_cause: assert property (p_ack_cause)
    else $error("read answer without read");
  a_state_layout: assert property (p_state_layout)
    else $error("bus state spare bits set");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_check_bit: assert property (p_check_bit)
    else $error("check sequence bit wrong");
  a_reset_flag: assert property (p_reset_flag)
    else $error("bus reset bit missing");
  a_count: assert property (p_count)
    else $error("cycle count wrong");
  a_events: assert property (p_events)
    else $error("event register wrong");
  a_cmd: assert property (p_cmd)
    else $error("command register wrong");
  a_mgmt_en: assert property (p_mgmt_en)
    else $error("message sent while channel off");
endmodule
